// [core/ripple_calibration_sequencer.sv]
// Calibration sequencer with switch control, fault flags, clocks and AXI4-Lite registers.
//
// Contract
// - Full calibration after power-up, fault, reset.
// - During calibration open inputs, connect test path.
// - Restore switches to pre-calibration state afterward.
// - One bit selects full or quick type.
// - Full calibration lasts about 85 ms.
// - Quick calibration lasts about 8 ms.
// - No extra calibrations unless scheduled or triggered.
// - Nonzero schedule field repeats calibration periodically.
// - Manual trigger bit starts selected calibration.
// - Set fault flag when rail below threshold.
// - Set output error flag on saturation.
// - Two gain bits choose unity, 1.25, 1.375.
// - Pump clock 16 MHz default, 8 MHz option.
// - Busy pin active while calibrating, when enabled.
// - Chop and pump clocks from 1 MHz master; the pump clock is divided directly from the system clock instead.
`timescale 1ns/1ps
module ripple_calibration_sequencer (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Register bus.
    input wire cal_pkg::axi_req_s axi_req,
    output cal_pkg::axi_rsp_s axi_rsp,
    // Analog monitors from comparators.
    input wire logic positive_high_rail_low,
    input wire logic negative_high_rail_low,
    input wire logic output_saturated,
    // Switch network and gain.
    output cal_pkg::switch_s switch_state,
    output logic output_gain_bit_low,
    output logic output_gain_bit_high,
    // Clocks.
    output logic master_clock,
    output logic chop_clock,
    output logic pump_clock,
    // Busy pin and interrupt.
    output logic busy_indicator_pin,
    output logic busy_indicator_pin_oe,
    output logic irq
);
    import cal_pkg::*;

    typedef enum logic [1:0] {st_idle, st_full, st_quick} state_e;

    state_e state;
    logic [31:0] ctrl;
    switch_s user_switches, saved_switches;
    logic manual_calibration_trigger, soft_reset_pulse;
    logic [2:0] irq_status, irq_enable;
    logic pos_meta, pos_sync, neg_meta, neg_sync, sat_meta, sat_sync;
    logic rail_low, rail_low_prev, fault_event, restart_full;
    logic high_rail_fault_flag, output_error_flag;
    logic start_full, start_quick, cal_done, cal_running;
    logic sched_expired, sched_running, sched_request;
    logic [2:0] sched_field;
    logic master_tick;
    logic [7:0] pump_half;
    logic aw_hold, w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    logic [31:0] next_rdata;
    logic next_rerr;

    always_ff @(posedge clock) begin
        pos_meta <= positive_high_rail_low;
        pos_sync <= pos_meta;
        neg_meta <= negative_high_rail_low;
        neg_sync <= neg_meta;
        sat_meta <= output_saturated;
        sat_sync <= sat_meta;
    end

    assign rail_low = pos_sync || neg_sync;
    assign fault_event = rail_low && !rail_low_prev;
    assign restart_full = srst || soft_reset_pulse || fault_event;

    always_ff @(posedge clock) begin
        if (srst || soft_reset_pulse) begin
            rail_low_prev <= 1'b0;
            high_rail_fault_flag <= 1'b0;
            output_error_flag <= 1'b0;
        end else begin
            rail_low_prev <= rail_low;
            if (rail_low) begin
                high_rail_fault_flag <= 1'b1;
            end
            if (sat_sync) begin
                output_error_flag <= 1'b1;
            end
        end
    end

    assign sched_field = ctrl[ctrl_sched_lsb +: 3];
    assign sched_request = (sched_field != 3'h0) && sched_expired;
    assign start_full = state == st_idle && !restart_full && ctrl[ctrl_cal_type_bit] == 1'b0
        && (manual_calibration_trigger || sched_request);
    assign start_quick = state == st_idle && !restart_full && ctrl[ctrl_cal_type_bit] == 1'b1
        && (manual_calibration_trigger || sched_request);
    assign cal_running = state != st_idle;

    cal_timer duration_timer (
        .clock(clock),
        .srst(1'b0),
        .load(restart_full || start_full || start_quick),
        .load_value((start_quick && !restart_full) ? quick_cal_cycles : full_cal_cycles),
        .stop(1'b0),
        .expired(cal_done),
        .running()
    );

    cal_timer schedule_timer (
        .clock(clock),
        .srst(srst),
        .load(!sched_running && sched_field != 3'h0),
        .load_value(sched_unit_cycles * {29'h0, sched_field}),
        .stop(sched_field == 3'h0),
        .running(sched_running),
        .expired(sched_expired)
    );

    always_ff @(posedge clock) begin
        if (restart_full) begin
            state <= st_full;
        end else begin
            case (state)
                st_idle: begin
                    if (start_full) begin
                        state <= st_full;
                    end else if (start_quick) begin
                        state <= st_quick;
                    end
                end
                st_full, st_quick: begin
                    if (cal_done) begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            saved_switches <= mux_reset;
        end else if (!cal_running && (restart_full || start_full || start_quick)) begin
            saved_switches <= user_switches;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            switch_state <= mux_reset;
        end else if (cal_running && !cal_done) begin
            switch_state <= 6'h30;
        end else begin
            switch_state <= cal_running ? saved_switches : user_switches;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            output_gain_bit_low <= 1'b0;
            output_gain_bit_high <= 1'b0;
            busy_indicator_pin <= 1'b0;
            busy_indicator_pin_oe <= 1'b0;
        end else begin
            output_gain_bit_low <= ctrl[ctrl_gain_lsb +: 2] == gain_one_25;
            output_gain_bit_high <= ctrl[ctrl_gain_lsb +: 2] == gain_one_375;
            busy_indicator_pin_oe <= ctrl[ctrl_busy_out_bit];
            busy_indicator_pin <= ctrl[ctrl_busy_out_bit] && cal_running;
        end
    end

    assign pump_half = ctrl[ctrl_pump_slow_bit] ? 8'(pump_slow_div) : 8'(pump_fast_div);

    clock_divider master_div_inst (
        .clock(clock),
        .srst(srst),
        .step(1'b1),
        .half_count(8'(master_div)),
        .clk_out(master_clock),
        .toggle(master_tick)
    );

    clock_divider chop_div_inst (
        .clock(clock),
        .srst(srst),
        .step(master_tick && !master_clock),
        .half_count(8'(chop_div)),
        .clk_out(chop_clock),
        .toggle()
    );

    clock_divider pump_div_inst (
        .clock(clock),
        .srst(srst),
        .step(1'b1),
        .half_count(pump_half),
        .clk_out(pump_clock),
        .toggle()
    );

    assign aw_ready = !aw_hold && !b_valid;
    assign w_ready = !w_hold && !b_valid;
    assign do_write = aw_hold && w_hold && !b_valid;
    assign axi_rsp = {aw_ready, w_ready, b_resp, b_valid, ar_ready, r_data, r_resp, r_valid};

    always_ff @(posedge clock) begin
        if (srst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            b_valid <= 1'b0;
            b_resp <= resp_okay;
        end else begin
            if (axi_req.awvalid && aw_ready) begin
                aw_hold <= 1'b1;
                aw_addr <= axi_req.awaddr;
            end
            if (axi_req.wvalid && w_ready) begin
                w_hold <= 1'b1;
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                b_valid <= 1'b1;
                b_resp <= (aw_addr > addr_soft_reset || aw_addr[1:0] != 2'b00)
                    ? resp_slverr : resp_okay;
            end else if (b_valid && axi_req.bready) begin
                b_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl <= ctrl_reset;
            user_switches <= mux_reset;
            irq_enable <= 3'h0;
            manual_calibration_trigger <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= do_write && aw_addr == addr_soft_reset && w_strb[0] && w_data[0];
            if (start_full || start_quick) begin
                manual_calibration_trigger <= 1'b0;
            end else if (do_write && aw_addr == addr_trig && w_strb[0] && w_data[0]) begin
                manual_calibration_trigger <= 1'b1;
            end
            if (do_write && aw_addr == addr_ctrl) begin
                for (int i = 0; i < 4; i++) begin
                    if (w_strb[i]) begin
                        ctrl[i*8 +: 8] <= w_data[i*8 +: 8];
                    end
                end
            end
            if (do_write && aw_addr == addr_mux && w_strb[0]) begin
                user_switches <= w_data[5:0];
            end
            if (do_write && aw_addr == addr_irq_enable && w_strb[0]) begin
                irq_enable <= w_data[2:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_status <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (do_write && aw_addr == addr_irq_clear && w_strb[0] && w_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            if (fault_event) begin
                irq_status[irq_fault_bit] <= 1'b1;
            end
            if (sat_sync) begin
                irq_status[irq_output_bit] <= 1'b1;
            end
            if (cal_running && cal_done) begin
                irq_status[irq_done_bit] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_status & irq_enable);

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rerr = 1'b0;
        case (axi_req.araddr)
            addr_ctrl: next_rdata = ctrl;
            addr_trig: next_rdata = {31'h0, manual_calibration_trigger};
            addr_mux: next_rdata = {26'h0, switch_state};
            addr_status: next_rdata = {28'h0, output_error_flag, high_rail_fault_flag,
                state == st_quick, cal_running};
            addr_irq_status: next_rdata = {29'h0, irq_status};
            addr_irq_enable: next_rdata = {29'h0, irq_enable};
            addr_irq_clear, addr_soft_reset: next_rdata = 32'h0000_0000;
            default: next_rerr = 1'b1;
        endcase
    end

    assign ar_ready = !r_valid;

    always_ff @(posedge clock) begin
        if (srst) begin
            r_valid <= 1'b0;
            r_data <= 32'h0000_0000;
            r_resp <= resp_okay;
        end else if (axi_req.arvalid && ar_ready) begin
            r_valid <= 1'b1;
            r_data <= next_rdata;
            r_resp <= next_rerr ? resp_slverr : resp_okay;
        end else if (r_valid && axi_req.rready) begin
            r_valid <= 1'b0;
        end
    end

    a_reset_starts_full: assert property (@(posedge clock) srst |=> state == st_full)
        else $error("reset did not start full calibration");
    a_switches_isolated: assert property (@(posedge clock) disable iff (srst)
        cal_running && !cal_done && !restart_full |=> switch_state == 6'h30)
        else $error("switches not isolated during calibration");
    a_switches_restored: assert property (@(posedge clock) disable iff (srst)
        state != st_idle ##1 state == st_idle |-> switch_state == $past(saved_switches))
        else $error("switches not restored");
    a_quick_selected: assert property (@(posedge clock) disable iff (srst)
        start_quick |=> state == st_quick)
        else $error("quick calibration not entered");
    a_trigger_clears: assert property (@(posedge clock) disable iff (srst)
        manual_calibration_trigger && state == st_idle && !restart_full
        |=> !manual_calibration_trigger && state != st_idle)
        else $error("trigger did not start and clear");
    a_no_abort: assert property (@(posedge clock) disable iff (srst)
        cal_running && !cal_done && !restart_full |=> cal_running)
        else $error("calibration aborted");
    a_fault_flag: assert property (@(posedge clock) disable iff (srst || soft_reset_pulse)
        rail_low |=> high_rail_fault_flag)
        else $error("rail fault flag not set");
    a_output_flag: assert property (@(posedge clock) disable iff (srst || soft_reset_pulse)
        sat_sync |=> output_error_flag)
        else $error("output error flag not set");
    a_busy_pin: assert property (@(posedge clock) disable iff (srst)
        ctrl[ctrl_busy_out_bit] && $past(ctrl[ctrl_busy_out_bit])
        |-> busy_indicator_pin == $past(cal_running))
        else $error("busy pin mismatch");
    a_fault_restart: assert property (@(posedge clock) disable iff (srst)
        fault_event |=> state == st_full)
        else $error("fault did not restart full calibration");
endmodule : ripple_calibration_sequencer

// [core/cal_pkg.sv]
// Package holding register map, field layouts, reset values and timing counts.
package cal_pkg;
    localparam int unsigned clock_hz = 200_000_000;
    localparam int unsigned master_hz = 1_000_000;
    localparam int unsigned chop_hz = 125_000;
    localparam int unsigned pump_fast_hz = 16_000_000;
    localparam int unsigned pump_slow_hz = 8_000_000;
    localparam int unsigned full_cal_ms = 85;
    localparam int unsigned quick_cal_ms = 8;
    localparam int unsigned full_cal_cycles = full_cal_ms * (clock_hz / 1000);
    localparam int unsigned quick_cal_cycles = quick_cal_ms * (clock_hz / 1000);
    localparam int unsigned master_div = clock_hz / master_hz / 2;
    localparam int unsigned chop_div = master_hz / chop_hz / 2;
    localparam int unsigned pump_fast_div = clock_hz / pump_fast_hz / 2;
    localparam int unsigned pump_slow_div = clock_hz / pump_slow_hz / 2;
    localparam int unsigned sched_unit_ms = 100;
    localparam int unsigned sched_unit_cycles = sched_unit_ms * (clock_hz / 1000);

    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_trig = 8'h04;
    localparam logic [7:0] addr_mux = 8'h08;
    localparam logic [7:0] addr_status = 8'h0c;
    localparam logic [7:0] addr_irq_status = 8'h10;
    localparam logic [7:0] addr_irq_enable = 8'h14;
    localparam logic [7:0] addr_irq_clear = 8'h18;
    localparam logic [7:0] addr_soft_reset = 8'h1c;

    localparam int unsigned ctrl_cal_type_bit = 0;
    localparam int unsigned ctrl_sched_lsb = 1;
    localparam int unsigned ctrl_gain_lsb = 4;
    localparam int unsigned ctrl_pump_slow_bit = 6;
    localparam int unsigned ctrl_busy_out_bit = 7;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [5:0] mux_reset = 6'h00;

    localparam int unsigned irq_fault_bit = 0;
    localparam int unsigned irq_output_bit = 1;
    localparam int unsigned irq_done_bit = 2;

    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [1:0] {gain_unity, gain_one_25, gain_one_375} gain_e;

    typedef struct packed {
        logic test_path_switch_second;
        logic test_path_switch_first;
        logic input_switch_second_b;
        logic input_switch_first_b;
        logic input_switch_second_a;
        logic input_switch_first_a;
    } switch_s;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_s;
endpackage : cal_pkg

// [core/clock_divider.sv]
// Toggle divider that produces a square wave from a clock enable source.
`timescale 1ns/1ps
module clock_divider #(
    parameter int unsigned half_period = 2
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Advance strobe and half period override.
    input wire logic step,
    input wire logic [7:0] half_count,
    // Divided clock and edge pulse.
    output logic clk_out,
    output logic toggle
);
    logic [7:0] count;

    assign toggle = step && (count >= half_count - 8'h01);

    always_ff @(posedge clock) begin
        if (srst) begin
            count <= 8'h00;
            clk_out <= 1'b0;
        end else if (step) begin
            if (toggle) begin
                count <= 8'h00;
                clk_out <= ~clk_out;
            end else begin
                count <= count + 8'h01;
            end
        end
    end
endmodule : clock_divider

// [core/cal_timer.sv]
// Down counter that times one calibration or one schedule interval.
`timescale 1ns/1ps
module cal_timer (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Load and abort.
    input wire logic load,
    input wire logic [31:0] load_value,
    input wire logic stop,
    // Status.
    output logic running,
    output logic expired
);
    logic [31:0] count;

    assign running = (count != 32'h0000_0000);
    assign expired = (count == 32'h0000_0001);

    always_ff @(posedge clock) begin
        if (srst || stop) begin
            count <= 32'h0000_0000;
        end else if (load) begin
            count <= load_value;
        end else if (running) begin
            count <= count - 32'h0000_0001;
        end
    end
endmodule : cal_timer

// [verif/tb_top.sv]
// Self-checking bench that drives the calibration sequencer through its register bus.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import cal_pkg::*;
    logic clock;
    logic srst;
    axi_req_s axi_req;
    axi_rsp_s axi_rsp;
    logic positive_high_rail_low;
    logic negative_high_rail_low;
    logic output_saturated;
    switch_s switch_state;
    logic output_gain_bit_low;
    logic output_gain_bit_high;
    logic master_clock;
    logic chop_clock;
    logic pump_clock;
    logic busy_indicator_pin;
    logic busy_indicator_pin_oe;
    logic irq;
    logic [2:0] clks;
    logic [31:0] rd;
    logic [1:0] rsp;
    int n_fail = 0;
    int n_checks = 0;
    int n;

    assign clks = {pump_clock, chop_clock, master_clock};

    ripple_calibration_sequencer ripple_calibration_sequencer_inst (
        .clock(clock),
        .srst(srst),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .positive_high_rail_low(positive_high_rail_low),
        .negative_high_rail_low(negative_high_rail_low),
        .output_saturated(output_saturated),
        .switch_state(switch_state),
        .output_gain_bit_low(output_gain_bit_low),
        .output_gain_bit_high(output_gain_bit_high),
        .master_clock(master_clock),
        .chop_clock(chop_clock),
        .pump_clock(pump_clock),
        .busy_indicator_pin(busy_indicator_pin),
        .busy_indicator_pin_oe(busy_indicator_pin_oe),
        .irq(irq)
    );

    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clock);
        axi_req.awaddr <= a;
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        forever begin
            @(posedge clock);
            if (aw && axi_rsp.awready) begin
                aw = 1'b0;
                axi_req.awvalid <= 1'b0;
            end
            if (w && axi_rsp.wready) begin
                w = 1'b0;
                axi_req.wvalid <= 1'b0;
            end
            if (axi_rsp.bvalid) begin
                rsp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rdreg(input logic [7:0] a);
        logic ar;
        ar = 1'b1;
        @(posedge clock);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        forever begin
            @(posedge clock);
            if (ar && axi_rsp.arready) begin
                ar = 1'b0;
                axi_req.arvalid <= 1'b0;
            end
            if (axi_rsp.rvalid) begin
                rd = axi_rsp.rdata;
                rsp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
                break;
            end
        end
    endtask : rdreg

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rdreg(a);
        `CHK(rd & m, e)
    endtask : rdchk

    // Skips the first, possibly partial, level and counts the next full one in cycles.
    task automatic half_period(input int sel, output int cnt);
        logic v;
        cnt = 0;
        v = clks[sel];
        while (clks[sel] === v) @(posedge clock);
        v = clks[sel];
        while (clks[sel] === v) begin
            @(posedge clock);
            cnt++;
        end
    endtask : half_period

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end

    initial begin
        srst = 1'b1;
        axi_req = '0;
        positive_high_rail_low = 1'b0;
        negative_high_rail_low = 1'b0;
        output_saturated = 1'b0;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(switch_state, 6'h30)
        rdchk(addr_status, 32'h3, 32'h1);
        rdchk(addr_ctrl, 32'hff, ctrl_reset & 32'hff);
        wr(addr_mux, 32'h05);
        rdchk(addr_mux, 32'h3f, 32'h30);
        `CHK(switch_state, 6'h30)
        for (int g = 0; g < 3; g++) begin
            wr(addr_ctrl, 32'(g) << ctrl_gain_lsb);
            repeat (2) @(posedge clock);
            `CHK({output_gain_bit_high, output_gain_bit_low}, 2'(g))
        end
        half_period(2, n);
        `CHK(n, pump_fast_div)
        wr(addr_ctrl, 32'h1 << ctrl_pump_slow_bit);
        repeat (4) @(posedge clock);
        half_period(2, n);
        `CHK(n, pump_slow_div)
        half_period(0, n);
        `CHK(n, master_div)
        half_period(1, n);
        `CHK(n, chop_div * master_div * 2)
        wr(addr_ctrl, 32'h1 << ctrl_busy_out_bit | 32'h1);
        rdchk(addr_ctrl, 32'hff, 32'h81);
        repeat (3) @(posedge clock);
        `CHK({busy_indicator_pin_oe, busy_indicator_pin}, 2'b11)
        wr(addr_trig, 32'h1);
        rdchk(addr_trig, 32'h1, 32'h1);
        rdchk(addr_status, 32'h3, 32'h1);
        wr(addr_irq_enable, 32'h7);
        positive_high_rail_low <= 1'b1;
        repeat (6) @(posedge clock);
        rdchk(addr_status, 32'hf, 32'h5);
        rdchk(addr_irq_status, 32'h7, 32'h1);
        `CHK(irq, 1'b1)
        positive_high_rail_low <= 1'b0;
        repeat (4) @(posedge clock);
        wr(addr_irq_clear, 32'h1);
        rdchk(addr_irq_status, 32'h7, 32'h0);
        rdchk(addr_irq_clear, 32'hffffffff, 32'h0);
        `CHK(irq, 1'b0)
        wr(addr_soft_reset, 32'h1);
        repeat (3) @(posedge clock);
        rdchk(addr_status, 32'hf, 32'h1);
        negative_high_rail_low <= 1'b1;
        repeat (6) @(posedge clock);
        rdchk(addr_status, 32'h4, 32'h4);
        negative_high_rail_low <= 1'b0;
        wr(addr_irq_enable, 32'h0);
        wr(addr_irq_clear, 32'h7);
        output_saturated <= 1'b1;
        repeat (6) @(posedge clock);
        rdchk(addr_status, 32'h8, 32'h8);
        rdchk(addr_irq_status, 32'h2, 32'h2);
        `CHK(irq, 1'b0)
        wr(addr_irq_enable, 32'h2);
        `CHK(irq, 1'b1)
        output_saturated <= 1'b0;
        repeat (4) @(posedge clock);
        wr(addr_irq_clear, 32'h2);
        rdchk(addr_irq_status, 32'h2, 32'h0);
        `CHK(irq, 1'b0)
        wr(8'h20, 32'h1);
        `CHK(rsp, resp_slverr)
        rdreg(8'h24);
        `CHK(rsp, resp_slverr)
        wr(8'h02, 32'h1);
        `CHK(rsp, resp_slverr)
        end_of_test();
    end
endmodule : tb_top
